// ===== rtl/gpio_port_pkg.sv
//**********************************************************************
// port constants
//**********************************************************************
// Contract
// [RULE_01] port reads return pin levels, not output latches
// [RULE_02] any reset sets all direction bits, all pins inputs
// [RULE_03] port register is 8 bits, bits 7..4 read zero
// [RULE_04] pin three is input only, driver never enabled
// [RULE_05] pull-ups and wake on pins 0,1,3 switched globally
// [RULE_06] pin three as master clear: pull-up on, wake off
// [RULE_07] direction register loaded only by direction-load, write only
// [RULE_08] direction one means high impedance, zero drives latch value
// [RULE_09] pin two: osc quarter, comparator out, timer clock, direction
// [RULE_10] inputs sampled at read only, latches hold until rewritten
// [RULE_11] bit set/clear reads pins, modifies one bit, writes all latches
// [RULE_12] status bit 7 set by pin-change wake reset, else cleared
// [RULE_13] status bit 6 set by comparator wake reset, else cleared
// [RULE_14] option bit 7 zero enables wake, bit 6 zero enables pull-ups
// [RULE_15] direction bit zero disables wake and pull-up of that pin
// [RULE_16] calibration bit 0 puts osc quarter on pin two
// [RULE_17] port writes land at cycle end, reads sample at start
// [RULE_18] port writes update latches of all pins, inputs included
package gpio_port_pkg;
   localparam logic [7:0] STATUS_OFFSET = 8'h03;
   localparam logic [7:0] PORT_OFFSET = 8'h06;
   localparam int PIN_WAKE_FLAG_BIT = 7;
   localparam int CMP_WAKE_FLAG_BIT = 6;
   localparam int WAKE_DISABLE_BIT = 7;
   localparam int PULLUP_DISABLE_BIT = 6;
   localparam int TIMER_SRC_BIT = 5;
   localparam int OSC_QUARTER_BIT = 0;
   localparam logic [3:0] DIR_RESET = 4'hf;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [3:0] LATCH_RESET = 4'h0;
   localparam logic CALIB_Q4_RESET = 1'b0;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [3:0] PORT_MASK = 4'hf;
   localparam logic [3:0] WAKE_PINS = 4'hb;
   typedef enum logic [1:0] {
      RST_OTHER_type_val,
      RST_PIN_WAKE_type_val,
      RST_CMP_WAKE_type_val
   } reset_cause_type;
endpackage : gpio_port_pkg

// ===== rtl/four_pin_io_port.sv
//**********************************************************************
// four pin i/o port
//**********************************************************************
module four_pin_io_port
   import gpio_port_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [1:0] i_reset_cause,
   input wire logic i_master_clear_enable,
   input wire logic i_comparator_enable,
   input wire logic i_comparator_out_enable,
   input wire logic i_comparator_output,
   input wire logic i_osc_quarter,
   input wire logic i_file_wr,
   input wire logic i_file_rd,
   input wire logic [7:0] i_file_addr,
   input wire logic [7:0] i_file_wdata,
   input wire logic i_bit_set_instr,
   input wire logic i_bit_clear_instr,
   input wire logic [2:0] i_bit_index,
   input wire logic i_direction_load,
   input wire logic i_option_load,
   input wire logic i_calib_load,
   input wire logic [7:0] i_w_data,
   input wire logic [3:0] i_pin_in,
   output logic [3:0] o_pin_out,
   output logic [3:0] o_pin_oe,
   output logic [3:0] o_pullup_en,
   output logic [3:0] o_wake_en,
   output logic o_timer_ext_clock_in,
   output logic [7:0] o_rdata,
   output logic [1:0] o_wake_flags
);
   //*******************************************************************
   // state
   //*******************************************************************
   logic [3:0] latch_reg;
   logic [3:0] latch_next;
   logic [3:0] dir_reg;
   logic [7:0] option_reg;
   logic calib_q4_reg;
   logic [1:0] wake_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // reads sample pins only, upper bits zero
   wire [7:0] pin_sample = {4'h0, i_pin_in & PORT_MASK}; // RULE_01 RULE_03 RULE_10
   wire port_wr = i_file_wr && (i_file_addr == PORT_OFFSET);
   wire port_rmw = i_bit_set_instr || i_bit_clear_instr;
   wire [7:0] bit_mask = 8'h01 << i_bit_index;
   wire [7:0] rmw_value = i_bit_set_instr ? (pin_sample | bit_mask) : (pin_sample & ~bit_mask);
   wire timer_src_ext = option_reg[TIMER_SRC_BIT];

   // latch next value: rmw writes back sampled pins
   always_comb begin
      latch_next = latch_reg; // RULE_10
      if (port_rmw) begin
         latch_next = rmw_value[3:0]; // RULE_11
      end else if (port_wr) begin
         latch_next = i_file_wdata[3:0]; // RULE_18
      end
   end

   // read data mux
   always_comb begin
      rdata_next = 8'h00;
      if (i_file_rd && i_file_addr == PORT_OFFSET) begin
         rdata_next = pin_sample; // RULE_01
      end else if (i_file_rd && i_file_addr == STATUS_OFFSET) begin
         rdata_next = {wake_reg, 6'h00};
      end
   end

   // registers; writes land at the cycle end edge
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         latch_reg <= LATCH_RESET;
         dir_reg <= DIR_RESET; // RULE_02
         option_reg <= OPTION_RESET;
         calib_q4_reg <= CALIB_Q4_RESET;
         rdata_reg <= RDATA_RESET;
         wake_reg <= {i_reset_cause == 2'(RST_PIN_WAKE_type_val),
                      i_reset_cause == 2'(RST_CMP_WAKE_type_val)}; // RULE_12 RULE_13
      end else begin
         latch_reg <= latch_next; // RULE_17
         rdata_reg <= rdata_next;
         if (i_direction_load) dir_reg <= i_w_data[3:0]; // RULE_07
         if (i_option_load) option_reg <= i_w_data;
         if (i_calib_load) calib_q4_reg <= i_w_data[OSC_QUARTER_BIT];
      end
   end

   // pin drivers with alternate-function precedence
   always_comb begin
      o_pin_out = latch_reg;
      o_pin_oe = ~dir_reg; // RULE_08
      if (i_comparator_enable) begin
         o_pin_oe[1:0] = 2'b00; // RULE_09
      end
      o_pin_oe[3] = 1'b0; // RULE_04
      if (calib_q4_reg) begin
         o_pin_oe[2] = 1'b1; // RULE_16
         o_pin_out[2] = i_osc_quarter;
      end else if (i_comparator_out_enable) begin
         o_pin_oe[2] = 1'b1; // RULE_09
         o_pin_out[2] = i_comparator_output;
      end else if (timer_src_ext) begin
         o_pin_oe[2] = 1'b0;
      end
   end

   // global pull-up and wake, overridden per pin
   always_comb begin
      o_pullup_en = {4{~option_reg[PULLUP_DISABLE_BIT]}} & WAKE_PINS & dir_reg; // RULE_05 RULE_14 RULE_15
      o_wake_en = {4{~option_reg[WAKE_DISABLE_BIT]}} & WAKE_PINS & dir_reg; // RULE_05 RULE_14 RULE_15
      if (i_master_clear_enable) begin
         o_pullup_en[3] = 1'b1; // RULE_06
         o_wake_en[3] = 1'b0; // RULE_06
      end
   end

   assign o_timer_ext_clock_in = i_pin_in[2];
   assign o_rdata = rdata_reg;
   assign o_wake_flags = wake_reg;

   //*******************************************************************
   // checks
   //*******************************************************************
   property p_rd_pins;
      @(posedge i_clk) disable iff (!i_rstn)
      i_file_rd && i_file_addr == PORT_OFFSET |=> o_rdata == {4'h0, $past(i_pin_in)};
   endproperty
   a_rd_pins: assert property (p_rd_pins) else $error("port read not pins"); // RULE_01
   property p_dir_reset;
      @(posedge i_clk) !i_rstn |=> o_pin_oe == 4'h0;
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("driver on after reset"); // RULE_02
   property p_p3_in;
      @(posedge i_clk) disable iff (!i_rstn) !o_pin_oe[3];
   endproperty
   a_p3_in: assert property (p_p3_in) else $error("pin three driven"); // RULE_04
   property p_master_clear;
      @(posedge i_clk) disable iff (!i_rstn)
      i_master_clear_enable |-> o_pullup_en[3] && !o_wake_en[3];
   endproperty
   a_master_clear: assert property (p_master_clear) else $error("master clear pin setup"); // RULE_06
   property p_dir_load;
      @(posedge i_clk) disable iff (!i_rstn)
      i_direction_load && !i_comparator_enable && !calib_q4_reg && !i_comparator_out_enable
      && !timer_src_ext ##1 !i_comparator_enable && !calib_q4_reg && !i_comparator_out_enable
      && !timer_src_ext |-> o_pin_oe[2:0] == ~$past(i_w_data[2:0]);
   endproperty
   a_dir_load: assert property (p_dir_load) else $error("direction not loaded"); // RULE_07
   property p_rmw;
      @(posedge i_clk) disable iff (!i_rstn)
      i_bit_set_instr && i_bit_index < 3'h4
      |=> latch_reg == ($past(i_pin_in) | (4'h1 << $past(i_bit_index[1:0])));
   endproperty
   a_rmw: assert property (p_rmw) else $error("bit set not rmw"); // RULE_11
   property p_q4;
      @(posedge i_clk) disable iff (!i_rstn)
      calib_q4_reg |-> o_pin_oe[2] && o_pin_out[2] == i_osc_quarter;
   endproperty
   a_q4: assert property (p_q4) else $error("osc quarter not on pin two"); // RULE_16
   property p_pu_dir;
      @(posedge i_clk) disable iff (!i_rstn)
      !dir_reg[0] |-> !o_pullup_en[0] && !o_wake_en[0];
   endproperty
   a_pu_dir: assert property (p_pu_dir) else $error("pull-up on output pin"); // RULE_15
   property p_wr;
      @(posedge i_clk) disable iff (!i_rstn)
      port_wr && !port_rmw |=> latch_reg == $past(i_file_wdata[3:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("port write lost"); // RULE_18
   property p_clr;
      @(posedge i_clk) disable iff (!i_rstn)
      i_bit_clear_instr && !i_bit_set_instr && i_bit_index < 3'h4
      |=> latch_reg == ($past(i_pin_in) & ~(4'h1 << $past(i_bit_index[1:0])));
   endproperty
   a_clr: assert property (p_clr) else $error("bit clear not rmw"); // RULE_11
   property p_latch_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      !port_wr && !port_rmw |=> $stable(latch_reg);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch changed unwritten"); // RULE_10
   property p_rd_upper;
      @(posedge i_clk) disable iff (!i_rstn)
      i_file_rd && i_file_addr == PORT_OFFSET |=> o_rdata[7:4] == 4'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("port upper bits not zero"); // RULE_03
   // wake flags: captured from the reset cause, read in status
   property p_rd_status;
      @(posedge i_clk) disable iff (!i_rstn)
      i_file_rd && i_file_addr == STATUS_OFFSET |=> o_rdata == {$past(o_wake_flags), 6'h00};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong"); // RULE_12
   property p_flag_pin;
      @(posedge i_clk)
      !i_rstn && i_reset_cause == 2'(RST_PIN_WAKE_type_val) |=> o_wake_flags == 2'b10;
   endproperty
   a_flag_pin: assert property (p_flag_pin) else $error("pin wake flag wrong"); // RULE_12
   property p_flag_cmp;
      @(posedge i_clk)
      !i_rstn && i_reset_cause == 2'(RST_CMP_WAKE_type_val) |=> o_wake_flags == 2'b01;
   endproperty
   a_flag_cmp: assert property (p_flag_cmp) else $error("comparator wake flag wrong"); // RULE_13
   property p_flag_other;
      @(posedge i_clk)
      !i_rstn && i_reset_cause == 2'(RST_OTHER_type_val) |=> o_wake_flags == 2'b00;
   endproperty
   a_flag_other: assert property (p_flag_other) else $error("wake flags not cleared"); // RULE_12
   // alternate functions and direction on the drivers
   property p_cmp_in;
      @(posedge i_clk) disable iff (!i_rstn)
      i_comparator_enable |-> o_pin_oe[1:0] == 2'b00;
   endproperty
   a_cmp_in: assert property (p_cmp_in) else $error("comparator input driven"); // RULE_09
   property p_cmp_out;
      @(posedge i_clk) disable iff (!i_rstn)
      !calib_q4_reg && i_comparator_out_enable |-> o_pin_oe[2] && o_pin_out[2] == i_comparator_output;
   endproperty
   a_cmp_out: assert property (p_cmp_out) else $error("comparator output missing"); // RULE_09
   property p_tmr;
      @(posedge i_clk) disable iff (!i_rstn)
      !calib_q4_reg && !i_comparator_out_enable && timer_src_ext |-> !o_pin_oe[2];
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer clock pin driven"); // RULE_09
   property p_dir_drive;
      @(posedge i_clk) disable iff (!i_rstn)
      !dir_reg[1] && !i_comparator_enable |-> o_pin_oe[1] && o_pin_out[1] == latch_reg[1];
   endproperty
   a_dir_drive: assert property (p_dir_drive) else $error("output pin not driven"); // RULE_08
   property p_pu_off;
      @(posedge i_clk) disable iff (!i_rstn)
      option_reg[PULLUP_DISABLE_BIT] && !i_master_clear_enable |-> o_pullup_en == 4'h0;
   endproperty
   a_pu_off: assert property (p_pu_off) else $error("pull-up on while disabled"); // RULE_14
   property p_wake_off;
      @(posedge i_clk) disable iff (!i_rstn)
      option_reg[WAKE_DISABLE_BIT] |-> o_wake_en == 4'h0;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake on while disabled"); // RULE_14
endmodule : four_pin_io_port

// ===== verification/pin_partner.sv
//**********************************************************************
// outside circuitry on the port pins
//**********************************************************************
module pin_partner (
   input wire logic i_clk,
   input wire logic [3:0] i_pin_out,
   input wire logic [3:0] i_pin_oe,
   input wire logic [3:0] i_pullup_en,
   input wire logic [3:0] i_ext_en,
   input wire logic [3:0] i_ext_val,
   output logic [3:0] o_level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] float_reg = 4'h5;
   // undriven pins wander every cycle
   always @(posedge i_clk) float_reg <= ~float_reg;
   // outside driver overpowers the port, then port driver, then pull-up
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (i_ext_en[i]) o_level[i] = i_ext_val[i];
         else if (i_pin_oe[i]) o_level[i] = i_pin_out[i];
         else if (i_pullup_en[i]) o_level[i] = 1'b1;
         else o_level[i] = float_reg[i];
      end
   end
endmodule : pin_partner

// ===== verification/test_four_pin_io_port.sv
//**********************************************************************
// port bench
//**********************************************************************
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_four_pin_io_port;
   import gpio_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_rstn = 0, clear_pin = 0, cmp_en = 0, osc = 1, wr = 0, rd = 0, bset = 0;
   logic bclr = 0, dir_ld = 0, opt_ld = 0, cal_ld = 0, cmp_out_en = 0, cmp_out = 0;
   logic [1:0] cause = 2'h0, flags;
   logic [2:0] idx = 3'h0;
   logic [3:0] pins, pout, oe, pu, wk, ext_en = 4'h0, ext_val = 4'h0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic tck;
   int miscompares = 0, samples_checked = 0;
   four_pin_io_port dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reset_cause(cause),
      .i_master_clear_enable(clear_pin), .i_comparator_enable(cmp_en),
      .i_comparator_out_enable(cmp_out_en), .i_comparator_output(cmp_out),
      .i_osc_quarter(osc), .i_file_wr(wr), .i_file_rd(rd),
      .i_file_addr(addr), .i_file_wdata(wdata), .i_bit_set_instr(bset),
      .i_bit_clear_instr(bclr), .i_bit_index(idx), .i_direction_load(dir_ld),
      .i_option_load(opt_ld), .i_calib_load(cal_ld), .i_w_data(wdata), .i_pin_in(pins),
      .o_pin_out(pout), .o_pin_oe(oe), .o_pullup_en(pu), .o_wake_en(wk),
      .o_timer_ext_clock_in(tck), .o_rdata(rdata), .o_wake_flags(flags));
   pin_partner far (.i_clk(i_clk), .i_pin_out(pout), .i_pin_oe(oe), .i_pullup_en(pu),
      .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pins));
   // clock
   initial begin
      forever #25 i_clk = ~i_clk;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   // one strobe: 0 wr,1 rd,2 dir,3 opt,4 cal,5 clr,6 set
   task automatic go(input int k, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      idx <= a[2:0];
      wdata <= d;
      case (k)
         0: wr <= 1;
         1: rd <= 1;
         2: dir_ld <= 1;
         3: opt_ld <= 1;
         4: cal_ld <= 1;
         5: bclr <= 1;
         default: bset <= 1;
      endcase
      @(posedge i_clk);
      {wr, rd, dir_ld, opt_ld, cal_ld, bclr, bset} <= 7'h00;
      #1;
   endtask : go
   task automatic rst(input logic [1:0] c);
      @(posedge i_clk);
      i_rstn <= 0;
      cause <= c;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1;
      #1;
   endtask : rst
   // watchdog
   initial begin
      repeat (2000) @(posedge i_clk);
      miscompares++;
      report_and_stop;
   end
   // tests
   initial begin
      rst(2'h0);
      `CHK("oe", 4'h0, oe)
      `CHK("pu", 4'h0, pu | wk)
      `CHK("flags", 2'h0, flags)
      go(0, PORT_OFFSET, 8'hfa);
      go(2, 8'h00, 8'h00);
      `CHK("oe", 4'h3, oe)
      `CHK("out", 3'h2, pout[2:0])
      @(posedge i_clk);
      ext_en <= 4'hd;
      ext_val <= 4'h9;
      go(1, PORT_OFFSET, 8'h00);
      `CHK("rd", 8'h0b, rdata)
      `CHK("tck", 1'b0, tck)
      go(5, 8'h01, 8'h00);
      `CHK("clr", 3'h1, pout[2:0])
      go(6, 8'h02, 8'h00);
      `CHK("set", 3'h5, pout[2:0])
      go(2, 8'h00, 8'hff);
      go(3, 8'h00, 8'h00);
      `CHK("pu", 4'hb, pu)
      `CHK("wk", 4'hb, wk)
      @(posedge i_clk);
      clear_pin <= 1;
      go(2, 8'h00, 8'hfc);
      `CHK("clear_pin", 8'h80, {pu, wk})
      @(posedge i_clk);
      cmp_en <= 1;
      cmp_out_en <= 1;
      #1;
      `CHK("cmp", 4'h4, oe)
      go(4, 8'h00, 8'h01);
      `CHK("osc", 2'h3, {oe[2], pout[2]})
      go(4, 8'h00, 8'h00);
      `CHK("cmp_out", 2'h2, {oe[2], pout[2]})
      @(posedge i_clk);
      cmp_out <= 1;
      go(3, 8'h00, 8'hff);
      `CHK("cmp_tmr", 2'h3, {oe[2], pout[2]})
      go(2, 8'h00, 8'h00);
      `CHK("dir_cmp", 4'h4, oe)
      @(posedge i_clk);
      cmp_out_en <= 0;
      #1;
      `CHK("tmr", 4'h0, oe)
      go(1, 8'h10, 8'h00);
      `CHK("unm", 8'h00, rdata)
      rst(2'h1);
      go(1, STATUS_OFFSET, 8'h00);
      `CHK("pwk", 8'h80, rdata)
      rst(2'h2);
      `CHK("cwk", 3'h1, {oe[2], flags})
      @(posedge i_clk);
      ext_val <= 4'hf;
      #1;
      `CHK("tck", 1'b1, tck)
      report_and_stop;
   end
endmodule : test_four_pin_io_port
